// ==== axis_write_pkg.sv ====
// Constants, types and register map of the two-axis write register bank.
// Notes on behaviour
// R01 - Sixteen-bit bus: address lines A2..A0, A2 most significant, pick eight write locations.
// R02 - Every write register is sixteen bits and takes a whole word per sixteen-bit bus write.
// R03 - Address 0 loads the command word: axis assignment plus command code.
// R04 - Mode registers 1..3 share addresses for both axes; a write hits the selected axis.
// R05 - The axis for shared mode addresses comes from the most recent command that names an axis.
// R06 - A no-operation command with an axis assignment only latches that axis; here it also loads O_CMD_WORD, though with no command strobe.
// R07 - Mode register 1 of each axis holds that axis's interrupt enables.
// R08 - Mode register 2 holds stop input, servo signal and limit mode settings.
// R09 - Mode register 3 holds deceleration, profile, pulse output and encoder settings.
// R10 - Address 4 sets the fourteen X-axis general-purpose output values.
// R11 - Address 5 sets the fourteen Y-axis general-purpose output values.
// R12 - Address 6 supplies bits 15..0 of the 32-bit data word.
// R13 - Address 7 supplies bits 31..16 of the 32-bit data word.
// R14 - Reset clears all mode registers and both general-purpose output registers.
// R15 - Eight-bit bus: command upper byte first, lower byte second; act on full word.
// R16 - The same axis selection steers reads of the shared per-axis status registers.
// R17 - A write is captured once, in the core clock, when the host strobe ends.
package axis_write_pkg;
    localparam int DATA_W    = 16;
    localparam int REG_AW    = 3;
    localparam int AXES      = 2;
    localparam int MODE_REGS = 3;
    localparam int GP_BITS   = 14;
    localparam int AXIS_X    = 0;
    localparam int AXIS_Y    = 1;

    // Write register offsets on the sixteen-bit bus.
    localparam logic [REG_AW-1:0] ADDR_COMMAND = 3'h0;
    localparam logic [REG_AW-1:0] ADDR_MODE1   = 3'h1;
    localparam logic [REG_AW-1:0] ADDR_MODE2   = 3'h2;
    localparam logic [REG_AW-1:0] ADDR_MODE3   = 3'h3;
    localparam logic [REG_AW-1:0] ADDR_GP_X    = 3'h4;
    localparam logic [REG_AW-1:0] ADDR_GP_Y    = 3'h5;
    localparam logic [REG_AW-1:0] ADDR_DATA_LO = 3'h6;
    localparam logic [REG_AW-1:0] ADDR_DATA_HI = 3'h7;

    // Command word fields.
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_CODE_W   = 8;
    localparam int CMD_AXIS_LSB = 8;
    localparam logic [CMD_CODE_W-1:0] CMD_NOP_CODE = 8'h1f;

    // Values after reset.
    localparam logic [DATA_W-1:0] MODE_RESET     = 16'h0000;
    localparam logic [DATA_W-1:0] GP_RESET       = 16'h0000;
    localparam logic [DATA_W-1:0] CMD_RESET      = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RESET     = 16'h0000;
    localparam logic [AXES-1:0]   AXIS_SEL_RESET = 2'h1;

    // Progress of a byte-wise command write.
    typedef enum {CMD_WAIT_HIGH, CMD_HIGH_HELD} cmd_byte_e;
endpackage

// ==== host_write_if.sv ====
// Interface carrying one captured host write from the strobe capture to the register bank.
interface host_write_if;
    import axis_write_pkg::*;
    logic              wr_pulse;
    logic [REG_AW-1:0] wr_reg;
    logic              wr_byte_hi;
    logic              bus8;
    logic [DATA_W-1:0] wr_data;
    modport capture (output wr_pulse, wr_reg, wr_byte_hi, bus8, wr_data);
    modport decode  (input  wr_pulse, wr_reg, wr_byte_hi, bus8, wr_data);
endinterface

// ==== write_strobe_capture.sv ====
// Host write strobe capture: turns a chip-select and write strobe into one write pulse.
module write_strobe_capture
    import axis_write_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_cs_n,
    input  wire logic              i_wr_n,
    input  wire logic              i_bus8,
    input  wire logic [3:0]        i_addr,
    input  wire logic [DATA_W-1:0] i_data,
    host_write_if.capture          wr
);
    logic              strobe_on;
    logic              strobe_r;
    logic              pulse_r;
    logic [REG_AW-1:0] reg_r;
    logic              byte_hi_r;
    logic              bus8_r;
    logic [DATA_W-1:0] data_r;

    // A write is active while both select and strobe are low.
    assign strobe_on = ~i_cs_n & ~i_wr_n;

    // Strobe history for end detection.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            strobe_r <= 1'b0;
        else
            strobe_r <= strobe_on;
    end

    // One pulse when the strobe ends, so a long strobe still writes once.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            pulse_r <= 1'b0;
        else
            pulse_r <= strobe_r & ~strobe_on; // [R17]
    end

    // Address and data follow the bus while the strobe is low; the last low cycle wins.
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            reg_r     <= ADDR_COMMAND;
            byte_hi_r <= 1'b0;
            bus8_r    <= 1'b0;
            data_r    <= DATA_RESET;
        end
        else if (strobe_on)
        begin
            bus8_r    <= i_bus8;
            reg_r     <= i_bus8 ? i_addr[3:1] : i_addr[2:0]; // [R01]
            byte_hi_r <= i_bus8 & i_addr[0];
            data_r    <= i_data; // [R02]
        end
    end

    assign wr.wr_pulse   = pulse_r;
    assign wr.wr_reg     = reg_r;
    assign wr.wr_byte_hi = byte_hi_r;
    assign wr.bus8       = bus8_r;
    assign wr.wr_data    = data_r;

    single_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst) // [R17]
        pulse_r |=> !pulse_r)
        else $error("write pulse lasted more than one cycle");
endmodule

// ==== two_axis_write_register_map.sv ====
// Write register bank of the two-axis motion controller: command, mode, output and data words.
module two_axis_write_register_map
    import axis_write_pkg::*;
#(
    parameter int                    GP_OUT_W = GP_BITS,
    parameter logic [CMD_CODE_W-1:0] NOP_CODE = CMD_NOP_CODE
)
(
    input  wire logic                I_CORE_CLK,
    input  wire logic                I_RST,
    input  wire logic                I_CS_N,
    input  wire logic                I_WR_N,
    input  wire logic                I_BUS8,
    input  wire logic [3:0]          I_ADDR,
    input  wire logic [DATA_W-1:0]   I_DATA,
    output logic      [DATA_W-1:0]   O_CMD_WORD,
    output logic                     O_CMD_STROBE,
    output logic      [AXES-1:0]     O_STATUS_AXIS_SEL,
    output logic      [DATA_W-1:0]   O_X_INT_EN_MODE,
    output logic      [DATA_W-1:0]   O_Y_INT_EN_MODE,
    output logic      [DATA_W-1:0]   O_X_SIG_LIMIT_MODE,
    output logic      [DATA_W-1:0]   O_Y_SIG_LIMIT_MODE,
    output logic      [DATA_W-1:0]   O_X_PROFILE_PULSE_MODE,
    output logic      [DATA_W-1:0]   O_Y_PROFILE_PULSE_MODE,
    output logic      [GP_OUT_W-1:0] O_X_GP_OUT,
    output logic      [GP_OUT_W-1:0] O_Y_GP_OUT,
    output logic      [2*DATA_W-1:0] O_WRITE_DATA
);
    host_write_if wr ();

    logic [DATA_W-1:0]     mode_r [AXES][MODE_REGS];
    logic [DATA_W-1:0]     gp_r [AXES];
    logic [DATA_W-1:0]     data_lo_r;
    logic [DATA_W-1:0]     data_hi_r;
    logic [DATA_W-1:0]     cmd_word_r;
    logic                  cmd_strobe_r;
    logic [7:0]            cmd_hi_r;
    logic [AXES-1:0]       axis_sel_r;
    cmd_byte_e             cmd_state_r;
    logic                  cmd_write;
    logic                  cmd_complete;
    logic [DATA_W-1:0]     cmd_full;
    logic                  cmd_is_nop;
    logic [AXES-1:0]       cmd_axis;

    // Outputs wider than a register word cannot be served.
    generate
        if (GP_OUT_W < 1 || GP_OUT_W > DATA_W)
        begin : gp_width_check
            $error("GP_OUT_W must lie between 1 and the register width");
        end
    endgenerate

    // True when the captured write is aimed at the given location.
    function automatic logic hits(input logic pulse, input logic [REG_AW-1:0] reg_idx,
                                  input logic [REG_AW-1:0] target);
        hits = pulse && (reg_idx == target);
    endfunction

    // A sixteen-bit write replaces the word; a byte write replaces one half only.
    function automatic logic [DATA_W-1:0] merge_word(input logic [DATA_W-1:0] old,
                                                     input logic [DATA_W-1:0] data,
                                                     input logic bus8, input logic hi);
        merge_word = old;
        if (!bus8)
            merge_word = data;
        else if (hi)
            merge_word[15:8] = data[7:0];
        else
            merge_word[7:0] = data[7:0];
    endfunction

    // The strobe capture delivers each host write as a single pulse.
    write_strobe_capture u_capture (
        .i_clk  (I_CORE_CLK),
        .i_rst  (I_RST),
        .i_cs_n (I_CS_N),
        .i_wr_n (I_WR_N),
        .i_bus8 (I_BUS8),
        .i_addr (I_ADDR),
        .i_data (I_DATA),
        .wr     (wr.capture)
    );

    // Assembly of the command word; on the byte bus only the lower byte completes it.
    assign cmd_write    = hits(wr.wr_pulse, wr.wr_reg, ADDR_COMMAND); // [R03]
    assign cmd_complete = cmd_write && (!wr.bus8 ||
                          (!wr.wr_byte_hi && cmd_state_r == CMD_HIGH_HELD)); // [R15]
    assign cmd_full     = wr.bus8 ? {cmd_hi_r, wr.wr_data[7:0]} : wr.wr_data;
    assign cmd_is_nop   = cmd_full[CMD_CODE_LSB +: CMD_CODE_W] == NOP_CODE;
    assign cmd_axis     = cmd_full[CMD_AXIS_LSB +: AXES];

    // Byte order tracker: a lower byte without a held upper byte is ignored.
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RST)
            cmd_state_r <= CMD_WAIT_HIGH;
        else if (cmd_write && !wr.bus8)
            cmd_state_r <= CMD_WAIT_HIGH;
        else if (cmd_write)
        begin
            case (cmd_state_r)
                CMD_WAIT_HIGH:
                begin
                    if (wr.wr_byte_hi)
                        cmd_state_r <= CMD_HIGH_HELD; // [R15]
                end
                CMD_HIGH_HELD:
                begin
                    if (!wr.wr_byte_hi)
                        cmd_state_r <= CMD_WAIT_HIGH;
                end
                default:
                    cmd_state_r <= CMD_WAIT_HIGH;
            endcase
        end
    end

    // The upper command byte waits here until its lower byte arrives.
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RST)
            cmd_hi_r <= 8'h00;
        else if (cmd_write && wr.bus8 && wr.wr_byte_hi)
            cmd_hi_r <= wr.wr_data[7:0];
    end

    // Complete command word, held for the execution logic.
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RST)
            cmd_word_r <= CMD_RESET;
        else if (cmd_complete)
            cmd_word_r <= cmd_full; // [R03]
    end

    // A no-operation command is never passed on for execution.
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RST)
            cmd_strobe_r <= 1'b0;
        else
            cmd_strobe_r <= cmd_complete && !cmd_is_nop; // [R06]
    end

    // Axis of the latest command; a command naming no axis leaves it alone.
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RST)
            axis_sel_r <= AXIS_SEL_RESET;
        else if (cmd_complete && cmd_axis != '0)
            axis_sel_r <= cmd_axis; // [R05] [R06]
    end

    // Per-axis mode registers share addresses; each copy listens only when its axis is picked.
    generate
        for (genvar ax = 0; ax < AXES; ax++)
        begin : g_axis
            for (genvar m = 0; m < MODE_REGS; m++)
            begin : g_mode
                localparam logic [REG_AW-1:0] MODE_ADDR = ADDR_MODE1 + REG_AW'(m);
                always_ff @(posedge I_CORE_CLK)
                begin
                    if (I_RST)
                        mode_r[ax][m] <= MODE_RESET; // [R14]
                    else if (hits(wr.wr_pulse, wr.wr_reg, MODE_ADDR) && axis_sel_r[ax])
                        mode_r[ax][m] <= merge_word(mode_r[ax][m], wr.wr_data,
                                                    wr.bus8, wr.wr_byte_hi); // [R04]
                end
            end

            // General-purpose outputs, one word per axis.
            localparam logic [REG_AW-1:0] GP_ADDR = (ax == AXIS_X) ? ADDR_GP_X : ADDR_GP_Y;
            always_ff @(posedge I_CORE_CLK)
            begin
                if (I_RST)
                    gp_r[ax] <= GP_RESET; // [R14]
                else if (hits(wr.wr_pulse, wr.wr_reg, GP_ADDR))
                    gp_r[ax] <= merge_word(gp_r[ax], wr.wr_data,
                                           wr.bus8, wr.wr_byte_hi); // [R10] [R11]
            end
        end
    endgenerate

    // Low half of the data word for a following data-writing command.
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RST)
            data_lo_r <= DATA_RESET;
        else if (hits(wr.wr_pulse, wr.wr_reg, ADDR_DATA_LO))
            data_lo_r <= merge_word(data_lo_r, wr.wr_data, wr.bus8, wr.wr_byte_hi); // [R12]
    end

    // High half of the data word.
    always_ff @(posedge I_CORE_CLK)
    begin
        if (I_RST)
            data_hi_r <= DATA_RESET;
        else if (hits(wr.wr_pulse, wr.wr_reg, ADDR_DATA_HI))
            data_hi_r <= merge_word(data_hi_r, wr.wr_data, wr.bus8, wr.wr_byte_hi); // [R13]
    end

    // Mode words feed interrupt, signal and profile logic of each axis.
    assign O_X_INT_EN_MODE        = mode_r[AXIS_X][0]; // [R07]
    assign O_Y_INT_EN_MODE        = mode_r[AXIS_Y][0]; // [R07]
    assign O_X_SIG_LIMIT_MODE     = mode_r[AXIS_X][1]; // [R08]
    assign O_Y_SIG_LIMIT_MODE     = mode_r[AXIS_Y][1]; // [R08]
    assign O_X_PROFILE_PULSE_MODE = mode_r[AXIS_X][2]; // [R09]
    assign O_Y_PROFILE_PULSE_MODE = mode_r[AXIS_Y][2]; // [R09]

    // Only the low bits reach pins; the upper register bits are stored but unused.
    assign O_X_GP_OUT   = gp_r[AXIS_X][GP_OUT_W-1:0]; // [R10]
    assign O_Y_GP_OUT   = gp_r[AXIS_Y][GP_OUT_W-1:0]; // [R11]
    assign O_WRITE_DATA = {data_hi_r, data_lo_r};

    // Status reads use the same axis choice as mode writes.
    assign O_STATUS_AXIS_SEL = axis_sel_r; // [R16]
    assign O_CMD_WORD        = cmd_word_r;
    assign O_CMD_STROBE      = cmd_strobe_r;

    // A full-word command shows up the cycle after its pulse, strobed unless it is a no-op.
    cmd_word_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R03]
        cmd_write && !wr.bus8 |=> O_CMD_WORD == $past(wr.wr_data)
                                  && O_CMD_STROBE == !$past(cmd_is_nop))
        else $error("command word not loaded from a sixteen-bit write");

    // A no-op gives no strobe yet still moves the axis selection.
    nop_axis_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R06]
        cmd_complete && cmd_is_nop && cmd_axis != '0
        |=> !O_CMD_STROBE && O_STATUS_AXIS_SEL == $past(cmd_axis))
        else $error("no-op command misbehaved");

    // The selection holds between commands.
    axis_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R05]
        !cmd_complete |=> $stable(O_STATUS_AXIS_SEL))
        else $error("axis selection moved without a command");

    // A mode write with only X selected leaves the Y copy alone and loads X.
    mode_x_only_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R04]
        hits(wr.wr_pulse, wr.wr_reg, ADDR_MODE2) && !wr.bus8 && axis_sel_r == 2'h1
        |=> $stable(O_Y_SIG_LIMIT_MODE) && O_X_SIG_LIMIT_MODE == $past(wr.wr_data))
        else $error("mode write reached the wrong axis");

    // The X copy ignores a mode 1 write when only Y is picked.
    mode_y_only_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R04]
        hits(wr.wr_pulse, wr.wr_reg, ADDR_MODE1) && axis_sel_r == 2'h2
        |=> $stable(O_X_INT_EN_MODE))
        else $error("X mode word changed while Y was selected");

    // After reset every mode and output word is zero.
    reset_clear_a: assert property (@(posedge I_CORE_CLK) // [R14]
        $past(I_RST) |-> O_X_INT_EN_MODE == '0 && O_Y_INT_EN_MODE == '0
                         && O_X_SIG_LIMIT_MODE == '0 && O_Y_SIG_LIMIT_MODE == '0
                         && O_X_PROFILE_PULSE_MODE == '0 && O_Y_PROFILE_PULSE_MODE == '0
                         && O_X_GP_OUT == '0 && O_Y_GP_OUT == '0)
        else $error("registers not cleared by reset");

    // Output word writes land on the right axis pins.
    gp_x_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R10]
        hits(wr.wr_pulse, wr.wr_reg, ADDR_GP_X) && !wr.bus8
        |=> O_X_GP_OUT == $past(wr.wr_data[GP_OUT_W-1:0]) && $stable(O_Y_GP_OUT))
        else $error("X output word not written");

    gp_y_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R11]
        hits(wr.wr_pulse, wr.wr_reg, ADDR_GP_Y) && !wr.bus8
        |=> O_Y_GP_OUT == $past(wr.wr_data[GP_OUT_W-1:0]) && $stable(O_X_GP_OUT))
        else $error("Y output word not written");

    // Data halves go to their own side of the 32-bit word.
    data_lo_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R12]
        hits(wr.wr_pulse, wr.wr_reg, ADDR_DATA_LO) && !wr.bus8
        |=> O_WRITE_DATA[15:0] == $past(wr.wr_data) && $stable(O_WRITE_DATA[31:16]))
        else $error("low data word not written");

    data_hi_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R13]
        hits(wr.wr_pulse, wr.wr_reg, ADDR_DATA_HI) && !wr.bus8
        |=> O_WRITE_DATA[31:16] == $past(wr.wr_data) && $stable(O_WRITE_DATA[15:0]))
        else $error("high data word not written");

    // An upper command byte alone never starts a command.
    byte_order_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R15]
        cmd_write && wr.bus8 && wr.wr_byte_hi |=> !O_CMD_STROBE && $stable(O_CMD_WORD))
        else $error("command acted on before its lower byte");

    // A lower byte with no upper byte held changes nothing.
    lone_byte_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R15]
        cmd_write && wr.bus8 && !wr.wr_byte_hi && cmd_state_r == CMD_WAIT_HIGH
        |=> !O_CMD_STROBE && $stable(O_CMD_WORD) && $stable(O_STATUS_AXIS_SEL))
        else $error("lone lower byte was used");

    // A byte-wise command is the held upper byte over the lower byte.
    byte_pair_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R15]
        cmd_complete && wr.bus8 |=> O_CMD_WORD == {$past(cmd_hi_r), $past(wr.wr_data[7:0])})
        else $error("byte command assembled wrongly");

    // Execution logic would run a command twice if the pulse stretched.
    strobe_once_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R17]
        O_CMD_STROBE |=> !O_CMD_STROBE)
        else $error("command pulse too long");

    // A command naming no axis keeps the choice; one naming an axis takes it.
    axis_keep_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R05]
        cmd_complete && cmd_axis == '0 |=> $stable(O_STATUS_AXIS_SEL))
        else $error("axis lost on axis-free command");

    axis_load_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R05]
        cmd_complete && cmd_axis != '0 |=> O_STATUS_AXIS_SEL == $past(cmd_axis))
        else $error("axis of command not taken");

    // The command word moves only when a command completes.
    cmd_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R03]
        !cmd_complete |=> $stable(O_CMD_WORD))
        else $error("command word moved");

    // With both axes picked, one mode write loads both copies.
    mode_both_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R04]
        hits(wr.wr_pulse, wr.wr_reg, ADDR_MODE1) && !wr.bus8 && axis_sel_r == 2'h3
        |=> O_X_INT_EN_MODE == $past(wr.wr_data) && O_Y_INT_EN_MODE == $past(wr.wr_data))
        else $error("shared mode write missed an axis");

    // An upper byte write keeps the lower half of the word.
    gp_byte_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R10]
        hits(wr.wr_pulse, wr.wr_reg, ADDR_GP_X) && wr.bus8 && wr.wr_byte_hi
        |=> gp_r[AXIS_X] == {$past(wr.wr_data[7:0]), $past(gp_r[AXIS_X][7:0])})
        else $error("byte write spoilt the other half");

    // Mode 3 with Y picked loads Y and leaves X.
    mode3_y_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST) // [R09]
        hits(wr.wr_pulse, wr.wr_reg, ADDR_MODE3) && !wr.bus8 && axis_sel_r == 2'h2
        |=> O_Y_PROFILE_PULSE_MODE == $past(wr.wr_data) && $stable(O_X_PROFILE_PULSE_MODE))
        else $error("mode 3 write reached the wrong axis");
endmodule

// ==== host_bus_model.sv ====
// Host CPU model that drives write cycles on the parallel bus of the register bank.
module host_bus_model
    import axis_write_pkg::*;
(
    input  wire logic              i_clk,
    output logic                   o_cs_n,
    output logic                   o_wr_n,
    output logic                   o_bus8,
    output logic [3:0]             o_addr,
    output logic [DATA_W-1:0]      o_data
);
    timeunit 1ns;
    timeprecision 100ps;

    // Bus idles deselected; the data lines start on a pattern that no test writes.
    initial
    begin
        o_cs_n = 1'b1;
        o_wr_n = 1'b1;
        o_bus8 = 1'b0;
        o_addr = 4'h0;
        o_data = 16'h5a5a;
    end

    // One write cycle: strobe low for the given number of cycles, then released.
    // Returning on the release edge lets the next call follow with a single idle edge.
    task automatic wr(input logic [3:0] addr, input logic [DATA_W-1:0] data,
                      input logic bus8, input int low_cycles);
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        o_wr_n <= 1'b0;
        o_bus8 <= bus8;
        o_addr <= addr;
        o_data <= data;
        repeat (low_cycles) @(posedge i_clk);
        o_cs_n <= 1'b1;
        o_wr_n <= 1'b1;
        // A released bus must not keep showing the written value.
        o_addr <= ~addr;
        o_data <= ~data;
    endtask

    // Byte-wide command write, upper byte always before lower byte.
    task automatic wr_cmd8(input logic [7:0] hi, input logic [7:0] lo);
        wr(4'h1, {8'h00, hi}, 1'b1, 1);
        wr(4'h0, {8'h00, lo}, 1'b1, 1);
    endtask
endmodule

// ==== tb_two_axis_write_register_map.sv ====
// Self-checking testbench of the two-axis write register bank.
module tb_two_axis_write_register_map
    import axis_write_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic                clk;
    logic                rst;
    logic                cs_n;
    logic                wr_n;
    logic                bus8;
    logic [3:0]          addr;
    logic [DATA_W-1:0]   data;
    logic [DATA_W-1:0]   cmd_word;
    logic                cmd_strobe;
    logic [AXES-1:0]     axis_sel;
    logic [DATA_W-1:0]   x_m1;
    logic [DATA_W-1:0]   y_m1;
    logic [DATA_W-1:0]   x_m2;
    logic [DATA_W-1:0]   y_m2;
    logic [DATA_W-1:0]   x_m3;
    logic [DATA_W-1:0]   y_m3;
    logic [GP_BITS-1:0]  x_gp;
    logic [GP_BITS-1:0]  y_gp;
    logic [2*DATA_W-1:0] wdata;
    int                  num_errors = 0;
    int                  tests_run  = 0;
    int                  strobes    = 0;
    int                  cycles     = 0;
    int                  n0;

    host_bus_model host (.i_clk(clk), .o_cs_n(cs_n), .o_wr_n(wr_n), .o_bus8(bus8),
                         .o_addr(addr), .o_data(data));

    two_axis_write_register_map dut (
        .I_CORE_CLK(clk), .I_RST(rst), .I_CS_N(cs_n), .I_WR_N(wr_n), .I_BUS8(bus8),
        .I_ADDR(addr), .I_DATA(data), .O_CMD_WORD(cmd_word), .O_CMD_STROBE(cmd_strobe),
        .O_STATUS_AXIS_SEL(axis_sel), .O_X_INT_EN_MODE(x_m1), .O_Y_INT_EN_MODE(y_m1),
        .O_X_SIG_LIMIT_MODE(x_m2), .O_Y_SIG_LIMIT_MODE(y_m2),
        .O_X_PROFILE_PULSE_MODE(x_m3), .O_Y_PROFILE_PULSE_MODE(y_m3),
        .O_X_GP_OUT(x_gp), .O_Y_GP_OUT(y_gp), .O_WRITE_DATA(wdata));

    // Clock at 40 MHz.
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Counts command pulses so that a doubled capture shows up as an extra one.
    always @(posedge clk)
    begin
        if (cmd_strobe === 1'b1)
            strobes <= strobes + 1;
    end

    // Hang guard: the whole sequence needs under a hundred cycles.
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            num_errors++;
            summarize();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // The write task returns on the release edge; outputs and the one-cycle pulse show two edges later.
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic chk_modes(input logic [15:0] x1, x2, x3, y1, y2, y3);
        check(x_m1, x1);
        check(x_m2, x2);
        check(x_m3, x3);
        check(y_m1, y1);
        check(y_m2, y2);
        check(y_m3, y3);
    endtask

    task automatic chk_reset();
        chk_modes(16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
        check(x_gp, 14'h0);
        check(y_gp, 14'h0);
        check(axis_sel, 2'b01);
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence: each write is followed by checks of the outputs it should move.
    initial
    begin
        rst = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk_reset();
        // Command on X: word, one-cycle pulse and axis selection.
        host.wr(4'h0, 16'h0120, 1'b0, 1);
        settle();
        check(cmd_word, 16'h0120);
        check(cmd_strobe, 1'b1);
        check(axis_sel, 2'b01);
        @(posedge clk);
        #1;
        check(cmd_strobe, 1'b0);
        // Back-to-back mode writes reach only the X copies.
        host.wr(4'h1, 16'h1111, 1'b0, 1);
        host.wr(4'h2, 16'h2222, 1'b0, 1);
        host.wr(4'h3, 16'h3333, 1'b0, 1);
        settle();
        chk_modes(16'h1111, 16'h2222, 16'h3333, 16'h0, 16'h0, 16'h0);
        // No-operation command moves the selection to Y and raises no pulse.
        host.wr(4'h0, {8'h02, CMD_NOP_CODE}, 1'b0, 1);
        settle();
        check(axis_sel, 2'b10);
        check(cmd_strobe, 1'b0);
        host.wr(4'h1, 16'haaaa, 1'b0, 1);
        host.wr(4'h2, 16'hbbbb, 1'b0, 1);
        host.wr(4'h3, 16'hcccc, 1'b0, 1);
        settle();
        chk_modes(16'h1111, 16'h2222, 16'h3333, 16'haaaa, 16'hbbbb, 16'hcccc);
        // Output registers; the top address line is not decoded on the wide bus.
        host.wr(4'h4, 16'hffff, 1'b0, 1);
        host.wr(4'hd, 16'h8001, 1'b0, 1);
        settle();
        check(x_gp, 14'h3fff);
        check(y_gp, 14'h0001);
        host.wr(4'h6, 16'hbeef, 1'b0, 1);
        host.wr(4'hf, 16'hdead, 1'b0, 1);
        settle();
        check(wdata, 32'hdeadbeef);
        // Byte bus on output words: each byte lands in its own half only.
        host.wr(4'h9, 16'h0012, 1'b1, 1);
        host.wr(4'ha, 16'h0034, 1'b1, 1);
        settle();
        check(x_gp, 14'h12ff);
        check(y_gp, 14'h0034);
        // Byte bus: a lone lower command byte is ignored, a proper pair acts.
        n0 = strobes;
        host.wr(4'h0, 16'h0040, 1'b1, 1);
        settle();
        check(cmd_strobe, 1'b0);
        check(axis_sel, 2'b10);
        host.wr_cmd8(8'h01, 8'h33);
        settle();
        check(cmd_word, 16'h0133);
        check(cmd_strobe, 1'b1);
        check(axis_sel, 2'b01);
        @(posedge clk);
        #1;
        check(strobes, n0 + 1);
        // A long strobe still gives exactly one capture.
        n0 = strobes;
        host.wr(4'h0, 16'h0255, 1'b0, 4);
        settle();
        repeat (3) @(posedge clk);
        #1;
        check(strobes, n0 + 1);
        check(axis_sel, 2'b10);
        // A command naming no axis keeps the choice; naming both feeds both mode copies.
        host.wr(4'h0, 16'h0033, 1'b0, 1);
        settle();
        check(cmd_word, 16'h0033);
        check(axis_sel, 2'b10);
        host.wr(4'h0, 16'h0333, 1'b0, 1);
        host.wr(4'h1, 16'h5555, 1'b0, 1);
        settle();
        check(axis_sel, 2'b11);
        chk_modes(16'h5555, 16'h2222, 16'h3333, 16'h5555, 16'hbbbb, 16'hcccc);
        // Reset in mid-run clears the mode and output registers again.
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk_reset();
        summarize();
    end
endmodule
